/* cics_regs.svh */
// Register offsets, field positions, reset values and encodings of the instruction cycle core
`ifndef CICS_REGS_SVH
`define CICS_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets (AXI4-Lite)
// ------------------------------------------------------------
`define CICS_OFF_CTRL      32'h0000_0000
`define CICS_OFF_FLAGS     32'h0000_0004
`define CICS_OFF_PC        32'h0000_0008
`define CICS_OFF_IR        32'h0000_000C

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CICS_CTRL_RUN      0
`define CICS_RUN_RST       1'b0
`define CICS_FLAGS_RST     5'h00
`define CICS_PC_RST        12'h000
`define CICS_NOP_WORD      16'h0000
`define CICS_W_RST         8'h00

// ------------------------------------------------------------
// Data memory map and bus answers
// ------------------------------------------------------------
`define CICS_STATUS_ADDR   8'hF8
`define CICS_FILE_TO_FILE_MOVE_INSTR_PAGE    4'hF
`define CICS_RESP_OKAY     2'b00
`define CICS_RESP_SLVERR   2'b10

`endif

/* cics_pkg.sv */
// Types shared by the instruction cycle core and its arithmetic unit
package cics_pkg;

	// ------------------------------------------------------------
	// Instruction opcodes, bits 15:12 of the instruction word
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP   = 4'h0,
		OP_MOVLW = 4'h1,
		OP_ADD   = 4'h2,
		OP_SUB   = 4'h3,
		OP_AND   = 4'h4,
		OP_CLR   = 4'h5,
		OP_ROTL  = 4'h6,
		OP_ROTR  = 4'h7,
		OP_BCLR  = 4'h8,
		OP_BSET  = 4'h9,
		OP_SWAP  = 4'hA,
		OP_WORKING_TO_FILE_MOVE_INSTR = 4'hB,
		OP_FILE_TO_FILE_MOVE_INSTR = 4'hC,
		OP_JUMP  = 4'hD
	} cics_op_t;

	typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cics_phase_t;

	typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_FLAGS, SEL_PC, SEL_IR} cics_sel_t;

	// Bit 4 down to bit 0 of the condition flags register
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} cics_flags_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} cics_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} cics_axi_rsp_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} cics_dm_req_t;

endpackage : cics_pkg

/* cics_alu.sv */
// Arithmetic unit: result and condition flags for one instruction
`timescale 1ns/100ps

module cics_alu (
	// Clock for the embedded checks only
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	// Operation and operands
	input  wire cics_pkg::cics_op_t i_op,
	input  wire logic [7:0]         i_f,
	input  wire logic [7:0]         i_w,
	input  wire logic [2:0]         i_bit,
	input  wire logic               i_c,
	// Result and flags
	output cics_pkg::cics_flags_t   o_flg,
	output cics_pkg::cics_flags_t   o_mask,
	output logic [7:0]              o_res
);
	import cics_pkg::*;

	function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		return {1'b0, a} + {1'b0, b} + {8'h00, cin};
	endfunction : add8

	function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
		return {1'b0, a} + {1'b0, b} + {4'h0, cin};
	endfunction : add4

	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] opb;

	always_comb begin
		sum9   = 9'h000;
		sum5   = 5'h00;
		opb    = i_w;
		o_res  = i_f;
		o_flg  = '0;
		o_mask = '0;
		unique case (i_op)
			OP_ADD, OP_SUB: begin
				// Subtract adds the two's complement, so carry reads as not-borrow
				opb      = (i_op == OP_SUB) ? ~i_w : i_w;
				sum9     = add8(i_f, opb, i_op == OP_SUB);
				sum5     = add4(i_f[3:0], opb[3:0], i_op == OP_SUB);
				o_res    = sum9[7:0];
				o_flg.c  = sum9[8];
				o_flg.dc = sum5[4];
				// Like-signed addends giving a result of the other sign
				o_flg.ov = (i_f[7] == opb[7]) && (sum9[7] != i_f[7]);
				o_mask   = '1;
			end
			OP_AND: begin
				o_res    = i_f & i_w;
				o_mask.n = 1'b1;
				o_mask.z = 1'b1;
			end
			OP_CLR: begin
				o_res    = 8'h00;
				o_mask.z = 1'b1;
			end
			OP_ROTL, OP_ROTR: begin
				o_res    = (i_op == OP_ROTL) ? {i_f[6:0], i_c} : {i_c, i_f[7:1]};
				o_flg.c  = (i_op == OP_ROTL) ? i_f[7] : i_f[0];
				o_flg.dc = (i_op == OP_ROTL) ? i_f[3] : i_f[4];
				o_mask   = '1;
				o_mask.ov = 1'b0;
			end
			// These leave every flag untouched
			OP_BCLR:  o_res = i_f & ~(8'h01 << i_bit);
			OP_BSET:  o_res = i_f | (8'h01 << i_bit);
			OP_SWAP:  o_res = {i_f[3:0], i_f[7:4]};
			OP_WORKING_TO_FILE_MOVE_INSTR: o_res = i_w;
			default:  o_res = i_f;
		endcase
		o_flg.z = (o_res == 8'h00);
		o_flg.n = o_res[7];
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_sub_borrow: assert property ((i_op == OP_SUB) |-> (o_flg.c == (i_f >= i_w)))
		else $error("sub carry is not inverted borrow");
	a_add_ovf: assert property ((i_op == OP_ADD) |->
		(o_flg.ov == ((i_f[7] == i_w[7]) && (o_res[7] != i_f[7]))))
		else $error("add overflow flag wrong");
	a_sub_ovf: assert property ((i_op == OP_SUB) |->
		(o_flg.ov == ((i_f[7] != i_w[7]) && (o_res[7] != i_f[7]))))
		else $error("sub overflow flag wrong");
	a_rot_left: assert property ((i_op == OP_ROTL) |-> (o_flg.dc == i_f[3] && o_flg.c == i_f[7]))
		else $error("rotate left flags wrong");
	a_rot_right: assert property ((i_op == OP_ROTR) |-> (o_flg.dc == i_f[4] && o_flg.c == i_f[0]))
		else $error("rotate right flags wrong");

endmodule : cics_alu

/* cics_core.sv */
// Instruction cycle core: phase divider, fetch/execute pipeline, condition flags and register slave
`timescale 1ns/100ps
`include "cics_regs.svh"

// Function
// - Clock divided into four one-hot phases
// - Program counter steps once in phase one
// - Fetch and execute overlap across cycles
// - Instruction register loads in phase one
// - Operand read phase two, write phase four
// - Jumps flush prefetch, take two cycles
// - Flags register usable as any operand
// - Flag-altering ops to flags store flags
// - Bit, swap, move ops keep flags
// - Flag bits: N4 OV3 Z2 DC1 C0
// - Subtract carries are inverted borrows
// - Rotates load DC and C from source
module cics_core (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	// Register bus
	input  wire cics_pkg::cics_axi_req_t i_axi,
	output cics_pkg::cics_axi_rsp_t     o_axi,
	// Program memory
	output logic [11:0]                 o_pm_addr,
	input  wire logic [15:0]            i_pm_data,
	// Data memory
	output cics_pkg::cics_dm_req_t      o_dm,
	input  wire logic [7:0]             i_dm_rdata,
	// Phase observation, bit 0 is phase one
	output logic [3:0]                  o_phase
);
	import cics_pkg::*;

	function automatic cics_sel_t reg_sel(input logic [31:0] a);
		logic [31:0] w;
		w = {a[31:2], 2'b00};
		if (w == `CICS_OFF_CTRL)
			return SEL_CTRL;
		else if (w == `CICS_OFF_FLAGS)
			return SEL_FLAGS;
		else if (w == `CICS_OFF_PC)
			return SEL_PC;
		else if (w == `CICS_OFF_IR)
			return SEL_IR;
		else
			return SEL_NONE;
	endfunction : reg_sel

	cics_phase_t phase_q;
	logic        run_q;
	logic [11:0] pc_q;
	logic [11:0] pm_addr_q;
	logic [15:0] prefetch_q;
	logic        flush_q;
	logic [15:0] ir_q;
	logic [7:0]  dm_addr_q;
	logic [7:0]  opnd_q;
	logic [7:0]  w_q;
	logic [7:0]  res_q;
	cics_flags_t flg_q;
	cics_flags_t mask_q;
	cics_flags_t flags_q;
	cics_flags_t alu_flg;
	cics_flags_t alu_mask;
	logic [7:0]  alu_res;
	cics_op_t    ir_op;
	logic        ph1, ph2, ph3, ph4;
	logic        rd_file, wr_file, wr_w, to_status;

	logic        aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [31:0] aw_addr_q, w_data_q, rdata_q, rd_mux;
	logic        w_strb0_q;
	logic [1:0]  bresp_q, rresp_q;
	logic        aw_take, w_take, ar_take, wr_fire, axi_wr_flags;
	cics_sel_t   wr_sel;

	// ------------------------------------------------------------
	// Phase divider
	// ------------------------------------------------------------
	assign ph1     = run_q && (phase_q == PH_ONE);
	assign ph2     = run_q && (phase_q == PH_TWO);
	assign ph3     = run_q && (phase_q == PH_THREE);
	assign ph4     = run_q && (phase_q == PH_FOUR);
	assign o_phase = {ph4, ph3, ph2, ph1};

	// Held while stopped, so the four phases never overlap
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			phase_q <= PH_ONE;
		end else if (run_q) begin
			unique case (phase_q)
				PH_ONE:   phase_q <= PH_TWO;
				PH_TWO:   phase_q <= PH_THREE;
				PH_THREE: phase_q <= PH_FOUR;
				PH_FOUR:  phase_q <= PH_ONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fetch stage
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pc_q      <= `CICS_PC_RST;
			pm_addr_q <= `CICS_PC_RST;
		end else if (ph1) begin
			pm_addr_q <= pc_q;
			pc_q      <= pc_q + 12'h001;
		end else if (ph4 && ir_op == OP_JUMP) begin
			pc_q      <= ir_q[11:0];
		end
	end
	assign o_pm_addr = pm_addr_q;

	// Word fetched during this cycle executes in the next one
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			prefetch_q <= `CICS_NOP_WORD;
		else if (ph4)
			prefetch_q <= i_pm_data;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			flush_q <= 1'b0;
		else if (ph4 && ir_op == OP_JUMP)
			flush_q <= 1'b1;
		else if (ph1)
			flush_q <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			ir_q <= `CICS_NOP_WORD;
		else if (ph1)
			ir_q <= flush_q ? `CICS_NOP_WORD : prefetch_q;
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign ir_op     = cics_op_t'(ir_q[15:12]);
	assign to_status = (dm_addr_q == `CICS_STATUS_ADDR);

	always_comb begin
		rd_file = 1'b0;
		wr_file = 1'b0;
		wr_w    = 1'b0;
		unique case (ir_op)
			OP_ADD, OP_SUB, OP_AND, OP_ROTL, OP_ROTR, OP_SWAP: begin
				rd_file = 1'b1;
				wr_file = ir_q[8];
				wr_w    = !ir_q[8];
			end
			OP_BCLR, OP_BSET, OP_FILE_TO_FILE_MOVE_INSTR: begin
				rd_file = 1'b1;
				wr_file = 1'b1;
			end
			OP_CLR, OP_WORKING_TO_FILE_MOVE_INSTR: wr_file = 1'b1;
			OP_MOVLW:         wr_w = 1'b1;
			default:          wr_file = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Execute stage
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			dm_addr_q <= 8'h00;
		else if (ph1)
			dm_addr_q <= flush_q ? 8'h00 : prefetch_q[7:0];
		else if (ph3 && ir_op == OP_FILE_TO_FILE_MOVE_INSTR)
			dm_addr_q <= {`CICS_FILE_TO_FILE_MOVE_INSTR_PAGE, ir_q[11:8]};
	end

	// Flags register is read in place of memory
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			opnd_q <= 8'h00;
		else if (ph2 && rd_file)
			opnd_q <= to_status ? {3'b000, flags_q} : i_dm_rdata;
		else if (ph2)
			opnd_q <= ir_q[7:0];
	end

	cics_alu u_alu (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_op    (ir_op),
		.i_f     (opnd_q),
		.i_w     (w_q),
		.i_bit   (ir_q[10:8]),
		.i_c     (flags_q.c),
		.o_flg   (alu_flg),
		.o_mask  (alu_mask),
		.o_res   (alu_res)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			res_q  <= 8'h00;
			flg_q  <= '0;
			mask_q <= '0;
		end else if (ph3) begin
			res_q  <= alu_res;
			flg_q  <= alu_flg;
			mask_q <= alu_mask;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			w_q <= `CICS_W_RST;
		else if (ph4 && wr_w)
			w_q <= res_q;
	end

	// Write-back never reaches memory at the flags address
	assign o_dm.addr  = dm_addr_q;
	assign o_dm.rd    = ph2 && rd_file && !to_status;
	assign o_dm.wr    = ph4 && wr_file && !to_status;
	assign o_dm.wdata = res_q;

	// Core write-back beats a simultaneous bus write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			flags_q <= `CICS_FLAGS_RST;
		else if (ph4 && wr_file && to_status && mask_q == '0)
			flags_q <= cics_flags_t'(res_q[4:0]);
		else if (ph4 && mask_q != '0)
			flags_q <= cics_flags_t'((flags_q & ~mask_q) | (flg_q & mask_q));
		else if (axi_wr_flags)
			flags_q <= cics_flags_t'(w_data_q[4:0]);
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign o_axi.awready = !aw_got_q && !bvalid_q;
	assign o_axi.wready  = !w_got_q && !bvalid_q;
	assign o_axi.arready = !rvalid_q;
	assign aw_take       = i_axi.awvalid && o_axi.awready;
	assign w_take        = i_axi.wvalid && o_axi.wready;
	assign ar_take       = i_axi.arvalid && o_axi.arready;
	assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;
	assign wr_sel        = reg_sel(aw_addr_q);
	assign axi_wr_flags  = wr_fire && wr_sel == SEL_FLAGS && w_strb0_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			aw_got_q  <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
		end else if (wr_fire) begin
			aw_got_q  <= 1'b0;
		end else if (aw_take) begin
			aw_got_q  <= 1'b1;
			aw_addr_q <= i_axi.awaddr;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			w_got_q   <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
		end else if (wr_fire) begin
			w_got_q   <= 1'b0;
		end else if (w_take) begin
			w_got_q   <= 1'b1;
			w_data_q  <= i_axi.wdata;
			w_strb0_q <= i_axi.wstrb[0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `CICS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_sel == SEL_NONE) ? `CICS_RESP_SLVERR : `CICS_RESP_OKAY;
		end else if (i_axi.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			run_q <= `CICS_RUN_RST;
		else if (wr_fire && wr_sel == SEL_CTRL && w_strb0_q)
			run_q <= w_data_q[`CICS_CTRL_RUN];
	end

	always_comb begin
		unique case (reg_sel(i_axi.araddr))
			SEL_CTRL:  rd_mux = {31'h0000_0000, run_q};
			SEL_FLAGS: rd_mux = {27'h000_0000, flags_q};
			SEL_PC:    rd_mux = {20'h0_0000, pc_q};
			SEL_IR:    rd_mux = {8'h00, w_q, ir_q};
			default:   rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `CICS_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= (reg_sel(i_axi.araddr) == SEL_NONE) ? `CICS_RESP_SLVERR : `CICS_RESP_OKAY;
		end else if (i_axi.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign o_axi.bvalid = bvalid_q;
	assign o_axi.bresp  = bresp_q;
	assign o_axi.rvalid = rvalid_q;
	assign o_axi.rdata  = rdata_q;
	assign o_axi.rresp  = rresp_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_phase_order: assert property (ph1 |=> phase_q == PH_TWO ##1 (!run_q || phase_q == PH_THREE))
		else $error("phase two does not follow phase one");
	a_phase_onehot: assert property ($onehot0(o_phase))
		else $error("phases overlap");
	a_pc_step: assert property (ph1 |=> pc_q == $past(pc_q) + 12'h001)
		else $error("pc did not step in phase one");
	a_pc_hold: assert property ((!ph1 && !(ph4 && ir_op == OP_JUMP)) |=> $stable(pc_q))
		else $error("pc moved outside phase one");
	a_fetch_overlap: assert property (ph4 |=> prefetch_q == $past(i_pm_data))
		else $error("prefetch not captured in phase four");
	a_ir_load: assert property ((ph1 && !flush_q) |=> ir_q == $past(prefetch_q))
		else $error("instruction register not loaded");
	a_dm_rd_phase: assert property (o_dm.rd |-> phase_q == PH_TWO)
		else $error("operand read outside phase two");
	a_dm_wr_phase: assert property (o_dm.wr |-> phase_q == PH_FOUR)
		else $error("write-back outside phase four");
	a_jump_flush: assert property ((ph4 && ir_op == OP_JUMP) |=> flush_q && pc_q == $past(ir_q[11:0]))
		else $error("jump did not flush");
	a_flush_nop: assert property ((ph1 && flush_q) |=> ir_q == `CICS_NOP_WORD && !flush_q)
		else $error("flushed word not turned into nop");
	a_status_src: assert property ((ph2 && rd_file && to_status) |=> opnd_q == {3'b000, $past(flags_q)})
		else $error("flags not read as operand");
	a_clear_status: assert property ((ph4 && ir_op == OP_CLR && to_status) |=>
		flags_q.z && flags_q.n == $past(flags_q.n) && flags_q.c == $past(flags_q.c))
		else $error("clear of flags register wrong");
	a_status_nowr: assert property (o_dm.wr |-> o_dm.addr != `CICS_STATUS_ADDR)
		else $error("memory written at flags address");
	a_flag_keep: assert property ((ph4 && !to_status && !axi_wr_flags &&
		ir_op inside {OP_BCLR, OP_BSET, OP_SWAP, OP_FILE_TO_FILE_MOVE_INSTR, OP_WORKING_TO_FILE_MOVE_INSTR}) |=> flags_q == $past(flags_q))
		else $error("flags changed by a flag-neutral op");
	a_unimpl_zero: assert property ((ar_take && reg_sel(i_axi.araddr) == SEL_FLAGS) |=>
		o_axi.rdata[31:5] == 27'h000_0000 && o_axi.rdata[4:0] == $past(flags_q))
		else $error("flags readback wrong");

	c_jump: cover property (ph4 && ir_op == OP_JUMP ##4 ph4);
	c_status_dest: cover property (ph4 && wr_file && to_status);
	c_sub_exec: cover property (ph4 && ir_op == OP_SUB);
	c_axi_flags: cover property (axi_wr_flags);

endmodule : cics_core

/* cics_mem_model.sv */
// Program memory and data memory model at the far side of the instruction cycle core
`timescale 1ns/100ps

module cics_mem_model (
	// Clock
	input  wire logic                   i_clk,
	// Program side
	input  wire logic [11:0]            i_pm_addr,
	output logic [15:0]                 o_pm_data,
	// Data side
	input  wire cics_pkg::cics_dm_req_t i_dm,
	output logic [7:0]                  o_dm_rdata
);
	import cics_pkg::*;

	logic [15:0] pm [4096];
	logic [7:0]  dm [256];
	logic [7:0]  last_q;

	initial last_q = 8'h5A;

	assign o_pm_data = pm[i_pm_addr];
	// Idle read lines show the inverse of the last value, so a stray capture is seen
	assign o_dm_rdata = i_dm.rd ? dm[i_dm.addr] : ~last_q;

	always @(posedge i_clk) begin
		if (i_dm.rd)
			last_q <= dm[i_dm.addr];
		if (i_dm.wr)
			dm[i_dm.addr] <= i_dm.wdata;
	end
endmodule : cics_mem_model

/* cpu_instruction_cycle_status_tb.sv */
// Self-checking bench for the instruction cycle core
`timescale 1ns/100ps
`include "cics_regs.svh"

`define CHK(got, exp, msg) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("ERROR t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
	end \
end

module cpu_instruction_cycle_status_tb;
	import cics_pkg::*;

	logic          i_clk;
	logic          i_rst_n;
	cics_axi_req_t axi;
	cics_axi_rsp_t o_axi;
	logic [11:0]   pm_addr;
	logic [15:0]   pm_data;
	cics_dm_req_t  dm;
	logic [7:0]    dm_rdata;
	logic [3:0]    phase;
	int            fails;
	int            samples_checked;
	int            cycles;

	// Whole run needs well under a thousand cycles
	localparam int LIMIT = 5000;

	cics_core u_cics_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(axi), .o_axi(o_axi), .o_pm_addr(pm_addr),
		.i_pm_data(pm_data), .o_dm(dm), .i_dm_rdata(dm_rdata), .o_phase(phase));
	cics_mem_model u_cics_mem_model (.i_clk(i_clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm(dm),
		.o_dm_rdata(dm_rdata));

	initial i_clk = 1'b0;
	always #10 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Register bus tasks
	// ------------------------------------------------------------
	task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		@(posedge i_clk);
		axi.awaddr  <= a;
		axi.awvalid <= 1'b1;
		axi.wdata   <= d;
		axi.wstrb   <= 4'hF;
		axi.wvalid  <= 1'b1;
		axi.bready  <= 1'b1;
		r = 2'b11;
		// Ends when the write response arrives; without one, the bench timeout ends it
		forever begin
			@(posedge i_clk);
			if (axi.awvalid && o_axi.awready)
				axi.awvalid <= 1'b0;
			if (axi.wvalid && o_axi.wready)
				axi.wvalid <= 1'b0;
			if (o_axi.bvalid) begin
				r = o_axi.bresp;
				axi.bready <= 1'b0;
				break;
			end
		end
		`CHK(r, er, "write response")
	endtask : wr_chk

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [1:0] r;
		logic [31:0] d;
		@(posedge i_clk);
		axi.araddr  <= a;
		axi.arvalid <= 1'b1;
		axi.rready  <= 1'b1;
		r = 2'b11;
		d = 'x;
		forever begin
			@(posedge i_clk);
			if (axi.arvalid && o_axi.arready)
				axi.arvalid <= 1'b0;
			if (o_axi.rvalid) begin
				r = o_axi.rresp;
				d = o_axi.rdata;
				axi.rready <= 1'b0;
				break;
			end
		end
		`CHK(r, er, "read response")
		`CHK(d, ed, "read data")
	endtask : rd_chk

	// ------------------------------------------------------------
	// Program run: reset, load, start, watch phases
	// ------------------------------------------------------------
	task automatic run_prog(input logic [15:0] p [8], input int n);
		int i;
		logic [11:0] pa;
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		for (i = 0; i < 4096; i++)
			u_cics_mem_model.pm[i] = (i < 8) ? p[i] : 16'h0000;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		wr_chk(`CICS_OFF_CTRL, 32'h0000_0001, `CICS_RESP_OKAY);
		for (i = 0; i < 8 && phase !== 4'h1; i++)
			@(negedge i_clk);
		pa = pm_addr;
		for (i = 1; i <= 8; i++) begin
			@(negedge i_clk);
			`CHK(phase, 4'h1 << (i % 4), "phase order")
			if (i == 4)
				pa = pm_addr;
		end
		`CHK(pm_addr, pa + 12'h001, "fetch address step")
		repeat (n) @(posedge i_clk);
	endtask : run_prog

	task automatic complete_run();
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_rst_n = 1'b0;
		axi = '0;
		for (int i = 0; i < 256; i++)
			u_cics_mem_model.dm[i] = 8'h00;
		u_cics_mem_model.dm[8'h10] = 8'h01;
		u_cics_mem_model.dm[8'h11] = 8'h7F;
		u_cics_mem_model.dm[8'h12] = 8'h88;
		u_cics_mem_model.dm[8'h13] = 8'h10;
		u_cics_mem_model.dm[8'h14] = 8'h3C;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		`CHK(phase, 4'h0, "stopped phase")
		rd_chk(`CICS_OFF_FLAGS, 32'h0000_0000, `CICS_RESP_OKAY);
		rd_chk(`CICS_OFF_CTRL, 32'h0000_0000, `CICS_RESP_OKAY);
		wr_chk(`CICS_OFF_PC, 32'h0000_0ABC, `CICS_RESP_OKAY);
		rd_chk(`CICS_OFF_PC, 32'h0000_0000, `CICS_RESP_OKAY);
		wr_chk(`CICS_OFF_FLAGS, 32'hFFFF_FFFF, `CICS_RESP_OKAY);
		rd_chk(`CICS_OFF_FLAGS, 32'h0000_001F, `CICS_RESP_OKAY);
		wr_chk(32'h0000_0010, 32'h0000_0001, `CICS_RESP_SLVERR);
		rd_chk(32'h0000_0010, 32'h0000_0000, `CICS_RESP_SLVERR);
		// Add with signed overflow, clear of flags, jump over a bit set
		run_prog('{16'h107F, 16'h2110, 16'h50F8, 16'hD005, 16'h9020, 16'hD005, 16'h0000, 16'h0000}, 60);
		rd_chk(`CICS_OFF_FLAGS, 32'h0000_001E, `CICS_RESP_OKAY);
		`CHK(u_cics_mem_model.dm[8'h10], 8'h80, "add write back")
		`CHK(u_cics_mem_model.dm[8'h20], 8'h00, "flushed bit set")
		// Subtract to zero: carries read as no borrow
		run_prog('{16'h107F, 16'h3111, 16'hD002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}, 60);
		rd_chk(`CICS_OFF_FLAGS, 32'h0000_0007, `CICS_RESP_OKAY);
		`CHK(u_cics_mem_model.dm[8'h11], 8'h00, "sub write back")
		// Move to flags, rotates, swap, bit clear, copy of flags out
		run_prog('{16'h100F, 16'hB0F8, 16'h6112, 16'h7113, 16'hA114, 16'h84F8, 16'hC6F8, 16'hD007}, 80);
		rd_chk(`CICS_OFF_FLAGS, 32'h0000_000A, `CICS_RESP_OKAY);
		`CHK(u_cics_mem_model.dm[8'h12], 8'h11, "rotate left")
		`CHK(u_cics_mem_model.dm[8'h13], 8'h88, "rotate right")
		`CHK(u_cics_mem_model.dm[8'h14], 8'hC3, "nibble swap")
		`CHK(u_cics_mem_model.dm[8'hF6], 8'h0A, "flags as source")
		rd_chk(`CICS_OFF_IR, {8'h00, 8'h0F, 16'hD007}, `CICS_RESP_OKAY);
		complete_run();
	end
endmodule : cpu_instruction_cycle_status_tb
